// ===== hdl/tlk_regs.svh
`ifndef TLK_REGS_SVH
`define TLK_REGS_SVH

// Lockdown-capable entries and the index that selects them
`define TLK_ENTRIES         8
`define TLK_IDX_W           3
// Address space identifier field in the virtual word
`define TLK_ADDRESS_SPACE_IDENTIFIER_HI         7
`define TLK_ADDRESS_SPACE_IDENTIFIER_LO         0
// Physical-page word fields
`define TLK_PA_VALID_BIT    0
`define TLK_PA_RSV_MASK     32'h0000_0f30
// Attribute word: only bits 11:0 are staged from writes and read back
`define TLK_ATTR_MASK       32'h0000_0fff
// Permission codes
`define TLK_AP_NONE         3'h0
`define TLK_AP_SUPV         3'h1
`define TLK_AP_USER_RO      3'h2
`define TLK_AP_FULL         3'h3
`define TLK_AP_RSV          3'h4
`define TLK_AP_SUPV_RO      3'h5
`define TLK_AP_ALL_RO_A     3'h6
`define TLK_AP_ALL_RO_B     3'h7
// Region extent codes and their page shifts
`define TLK_SZ_SUPER        2'h0
`define TLK_SZ_4K           2'h1
`define TLK_SZ_64K          2'h2
`define TLK_SZ_1M           2'h3
`define TLK_SHIFT_SUPER     5'h18
`define TLK_SHIFT_4K        5'h0c
`define TLK_SHIFT_64K       5'h10
`define TLK_SHIFT_1M        5'h14
// Return address offset after an interrupted invalidation
`define TLK_LR_OFFSET       32'h0000_0004
`define TLK_WORD_RESET      32'h0000_0000

`endif

// ===== hdl/tlk_pkg.sv
package tlk_pkg;

	typedef enum logic [2:0]
	{
		TLK_OP_SEL_RD,
		TLK_OP_SEL_WR,
		TLK_OP_VA,
		TLK_OP_PA,
		TLK_OP_ATTR,
		TLK_OP_INV_ADDRESS_SPACE_IDENTIFIER
	} tlk_op_t;

	typedef enum logic {TLK_IDLE, TLK_WALK} tlk_state_t;

	typedef struct packed
	{
		logic [19:0] physical_page_number;
		logic [3:0]  rsv_hi;
		logic [1:0]  region_extent;
		logic [1:0]  rsv_lo;
		logic [2:0]  access_permission_code;
		logic        locked_valid;
	} tlk_pa_word_t;

	typedef struct packed
	{
		logic [19:0] rsv;
		logic        nonsecure_flag;
		logic [3:0]  domain;
		logic        execute_never_flag;
		logic [2:0]  region_type_extension;
		logic [1:0]  cacheable_bufferable_pair;
		logic        shareable;
	} tlk_attr_word_t;

	typedef struct packed
	{
		logic        valid;
		logic        write;
		tlk_op_t     op;
		logic [31:0] wdata;
		logic [31:0] pc;
	} tlk_req_t;

	typedef struct packed
	{
		logic           valid;
		logic [2:0]     index;
		logic           global_entry;
		logic [31:0]    va;
		tlk_pa_word_t   pa;
		tlk_attr_word_t attr;
	} tlk_fill_t;

	typedef struct packed
	{
		logic       valid;
		logic [2:0] index;
		logic       user;
		logic       write;
		logic       execute;
	} tlk_chk_t;

endpackage

// ===== hdl/tlk_lockdown.sv
// Contract
// (R01) The physical-page word keeps the page number in bits 31:12; untranslated bits are kept as written (the code clears reserved bits 11:8 and 5:4 on write).
// (R02) Region extent bits 7:6 decode 00 supersection, 01 4KB, 10 64KB, 11 1MB.
// (R03) Permission 000 faults every access; 001 faults any user access.
// (R04) Permission 010 faults user writes only; 011 never faults.
// (R05) Permission 100 is reserved; 101 allows supervisor reads only; 110 and 111 allow reads only.
// (R06) Bit 0 of the physical-page word marks the entry locked and valid.
// (R07) Attribute bits 11, 10:7 and 6 hold nonsecure, domain and execute-never; bits 31:12 read zero.
// (R08) Attribute bits 5:3, 2:1 and 0 hold type extension, cacheable/bufferable and shareable.
// (R09) Each entry holds one permission code for its whole region, with no subpages.
// (R10) Invalidate by identifier removes every matching entry, locked ones included.
// (R11) Invalidate by identifier leaves global entries alone.
// (R12) An interrupted invalidation reports a link return value of its own address plus 4.
// (R13) A restarted invalidation also removes matching entries loaded meanwhile.
// (R14) Software selects the index first and accesses the physical-page word last.
// (R15) A physical-page write commits the staged words; reads show the entry selected for reading.
// (R16) The core is stalled during an invalidation unless an interrupt aborts it.
`timescale 1ns/1ps
`include "tlk_regs.svh"

module tlk_lockdown
(
	input  wire logic             clock,
	input  wire logic             reset,
	input  wire tlk_pkg::tlk_req_t  req,
	output logic                  req_ready,
	output logic [31:0]           rd_data,
	output logic                  rd_valid,
	input  wire logic             irq_pending,
	output logic                  abort_valid,
	output logic [31:0]           link_return_register,
	input  wire tlk_pkg::tlk_fill_t fill,
	input  wire tlk_pkg::tlk_chk_t  chk,
	output logic                  chk_done,
	output logic                  chk_fault,
	output logic [4:0]            chk_extent_log2
);

	tlk_pkg::tlk_state_t     state_q;
	tlk_pkg::tlk_pa_word_t   pa_q     [`TLK_ENTRIES];
	tlk_pkg::tlk_attr_word_t attr_q   [`TLK_ENTRIES];
	logic [31:0]             va_q     [`TLK_ENTRIES];
	logic [`TLK_ENTRIES-1:0] valid_q;
	logic [`TLK_ENTRIES-1:0] glob_q;
	logic [`TLK_IDX_W-1:0]   sel_rd_q;
	logic [`TLK_IDX_W-1:0]   sel_wr_q;
	logic [`TLK_IDX_W-1:0]   walk_idx_q;
	logic [31:0]             va_stage_q;
	logic [31:0]             attr_stage_q;
	logic [7:0]              address_space_identifier_q;
	logic [31:0]             pc_q;
	logic                    take;
	logic                    take_inv;
	logic                    walk_hit;
	logic                    walk_last;
	tlk_pkg::tlk_pa_word_t   pa_wr;
	tlk_pkg::tlk_pa_word_t   chk_pa;
	logic                    chk_xn;

	function automatic logic ap_fault(input logic [2:0] ap, input logic user, input logic write);
		case (ap)
			`TLK_AP_NONE:     ap_fault = 1'b1;                    // [R03]
			`TLK_AP_SUPV:     ap_fault = user;                    // [R03]
			`TLK_AP_USER_RO:  ap_fault = user & write;            // [R04]
			`TLK_AP_FULL:     ap_fault = 1'b0;                    // [R04]
			`TLK_AP_RSV:      ap_fault = 1'b1;                    // [R05]
			`TLK_AP_SUPV_RO:  ap_fault = user | write;            // [R05]
			default:          ap_fault = write;                   // [R05]
		endcase
	endfunction

	function automatic logic [4:0] extent_shift(input logic [1:0] sz);
		case (sz)
			`TLK_SZ_SUPER: extent_shift = `TLK_SHIFT_SUPER;       // [R02]
			`TLK_SZ_4K:    extent_shift = `TLK_SHIFT_4K;          // [R02]
			`TLK_SZ_64K:   extent_shift = `TLK_SHIFT_64K;         // [R02]
			default:       extent_shift = `TLK_SHIFT_1M;          // [R02]
		endcase
	endfunction

	// Stall the core while walking; new operations wait for the walk to end
	assign req_ready = (state_q == tlk_pkg::TLK_IDLE);                          // [R16]
	assign take      = req.valid && req_ready;
	assign take_inv  = take && req.write && (req.op == tlk_pkg::TLK_OP_INV_ADDRESS_SPACE_IDENTIFIER);
	assign walk_last = (walk_idx_q == `TLK_IDX_W'(`TLK_ENTRIES - 1));
	// Locked entries match too; only the global mark protects an entry
	assign walk_hit  = valid_q[walk_idx_q] && !glob_q[walk_idx_q]               // [R10] [R11]
		&& (va_q[walk_idx_q][`TLK_ADDRESS_SPACE_IDENTIFIER_HI:`TLK_ADDRESS_SPACE_IDENTIFIER_LO] == address_space_identifier_q);

	// Reserved bits of the physical word are dropped on write
	assign pa_wr = tlk_pkg::tlk_pa_word_t'(req.wdata & ~`TLK_PA_RSV_MASK);      // [R01]
	assign chk_pa = pa_q[chk.index];
	assign chk_xn = attr_q[chk.index].execute_never_flag;

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			state_q    <= tlk_pkg::TLK_IDLE;
			walk_idx_q <= '0;
			address_space_identifier_q     <= 8'h00;
			pc_q       <= `TLK_WORD_RESET;
		end
		else
		begin
			case (state_q)
				tlk_pkg::TLK_IDLE:
				begin
					if (take_inv)
					begin
						state_q    <= tlk_pkg::TLK_WALK;
						walk_idx_q <= '0;
						address_space_identifier_q     <= req.wdata[`TLK_ADDRESS_SPACE_IDENTIFIER_HI:`TLK_ADDRESS_SPACE_IDENTIFIER_LO];
						pc_q       <= req.pc;
					end
				end
				tlk_pkg::TLK_WALK:
				begin
					if (irq_pending || walk_last)
						state_q <= tlk_pkg::TLK_IDLE;                        // [R12] [R16]
					else
						walk_idx_q <= walk_idx_q + `TLK_IDX_W'(1);
				end
				default:
					state_q <= tlk_pkg::TLK_IDLE;
			endcase
		end
	end

	// The restarted walk revisits every entry, so anything loaded meanwhile is caught
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			abort_valid          <= 1'b0;
			link_return_register <= `TLK_WORD_RESET;
		end
		else
		begin
			abort_valid <= (state_q == tlk_pkg::TLK_WALK) && irq_pending;         // [R12] [R13]
			if ((state_q == tlk_pkg::TLK_WALK) && irq_pending)
				link_return_register <= pc_q + `TLK_LR_OFFSET;                   // [R12]
		end
	end

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			sel_rd_q     <= '0;
			sel_wr_q     <= '0;
			va_stage_q   <= `TLK_WORD_RESET;
			attr_stage_q <= `TLK_WORD_RESET;
		end
		else if (take && req.write)
		begin
			case (req.op)
				tlk_pkg::TLK_OP_SEL_RD: sel_rd_q     <= req.wdata[`TLK_IDX_W-1:0];
				tlk_pkg::TLK_OP_SEL_WR: sel_wr_q     <= req.wdata[`TLK_IDX_W-1:0];
				tlk_pkg::TLK_OP_VA:     va_stage_q   <= req.wdata;
				tlk_pkg::TLK_OP_ATTR:   attr_stage_q <= req.wdata & `TLK_ATTR_MASK; // [R07] [R08]
				default:                sel_rd_q     <= sel_rd_q;
			endcase
		end
	end

	// Entry store; the fill from the walker wins over a clear at the same index
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			valid_q <= '0;
			glob_q  <= '0;
			for (int i = 0; i < `TLK_ENTRIES; i++)
			begin
				va_q[i]   <= `TLK_WORD_RESET;
				pa_q[i]   <= tlk_pkg::tlk_pa_word_t'(`TLK_WORD_RESET);
				attr_q[i] <= tlk_pkg::tlk_attr_word_t'(`TLK_WORD_RESET);
			end
		end
		else
		begin
			if ((state_q == tlk_pkg::TLK_WALK) && !irq_pending && walk_hit)
			begin
				valid_q[walk_idx_q]              <= 1'b0;                    // [R10] [R13]
				pa_q[walk_idx_q].locked_valid    <= 1'b0;
			end
			// Commit on the physical word, which software writes last
			if (take && req.write && (req.op == tlk_pkg::TLK_OP_PA))
			begin
				va_q[sel_wr_q]    <= va_stage_q;                             // [R15] [R14]
				attr_q[sel_wr_q]  <= tlk_pkg::tlk_attr_word_t'(attr_stage_q); // [R15]
				pa_q[sel_wr_q]    <= pa_wr;                                  // [R01] [R09]
				valid_q[sel_wr_q] <= req.wdata[`TLK_PA_VALID_BIT];           // [R06]
				glob_q[sel_wr_q]  <= 1'b0;
			end
			if (fill.valid)
			begin
				va_q[fill.index]    <= fill.va;
				pa_q[fill.index]    <= fill.pa;
				attr_q[fill.index]  <= fill.attr;
				valid_q[fill.index] <= 1'b1;
				glob_q[fill.index]  <= fill.global_entry;
			end
		end
	end

	// Reads come from the entry selected for reading, one cycle after the request
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			rd_valid <= 1'b0;
			rd_data  <= `TLK_WORD_RESET;
		end
		else
		begin
			rd_valid <= take && !req.write && (req.op inside
				{tlk_pkg::TLK_OP_VA, tlk_pkg::TLK_OP_PA, tlk_pkg::TLK_OP_ATTR});
			if (take && !req.write)
			begin
				case (req.op)
					tlk_pkg::TLK_OP_VA:   rd_data <= va_q[sel_rd_q];          // [R15]
					tlk_pkg::TLK_OP_PA:   rd_data <= {pa_q[sel_rd_q][31:1],   // [R06]
						valid_q[sel_rd_q]};
					tlk_pkg::TLK_OP_ATTR: rd_data <= 32'(attr_q[sel_rd_q])
						& `TLK_ATTR_MASK;                                  // [R07]
					default:              rd_data <= rd_data;
				endcase
			end
		end
	end

	// Permission check against one region-wide code; execute-never adds a fault
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			chk_done        <= 1'b0;
			chk_fault       <= 1'b0;
			chk_extent_log2 <= 5'h00;
		end
		else
		begin
			chk_done <= chk.valid;
			if (chk.valid)
			begin
				chk_fault <= ap_fault(chk_pa.access_permission_code, chk.user, chk.write) // [R09]
					|| (chk.execute && chk_xn);
				chk_extent_log2 <= extent_shift(chk_pa.region_extent);            // [R02]
			end
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	// Neither the VA staging nor either select may move, and nothing is read, while the core is held off
	AST_STALL: assert property ((state_q == tlk_pkg::TLK_WALK) |-> (!req_ready ##1 // [R16]
		($stable(va_stage_q) && $stable(sel_wr_q) && $stable(sel_rd_q) && !rd_valid)))
		else $error("request accepted during walk");
	AST_ABORT: assert property (((state_q == tlk_pkg::TLK_WALK) && irq_pending) |=> // [R12]
		(abort_valid && (link_return_register == $past(pc_q) + `TLK_LR_OFFSET) && req_ready))
		else $error("abort did not report address plus four");
	AST_WALK_LEN: assert property ((take_inv && !irq_pending) ##1 (!irq_pending)[*8] // [R16]
		|=> req_ready)
		else $error("walk did not end after all entries");
	AST_CLEAR: assert property (((state_q == tlk_pkg::TLK_WALK) && !irq_pending // [R10]
		&& walk_hit && !fill.valid && !take) |=> !valid_q[$past(walk_idx_q)])
		else $error("matching entry survived the walk");
	AST_GLOBAL: assert property (((state_q == tlk_pkg::TLK_WALK) && glob_q[walk_idx_q] // [R11]
		&& valid_q[walk_idx_q]) |=> valid_q[$past(walk_idx_q)])
		else $error("global entry was removed");
	AST_COMMIT: assert property ((take && req.write && (req.op == tlk_pkg::TLK_OP_PA) // [R06]
		&& !fill.valid) |=> (valid_q[$past(sel_wr_q)] == $past(req.wdata[0])))
		else $error("physical write did not commit the valid flag");
	AST_RD_LAT: assert property ((take && !req.write && (req.op == tlk_pkg::TLK_OP_ATTR)) // [R07]
		|=> (rd_valid && (rd_data[31:12] == 20'h00000)))
		else $error("attribute read late or upper bits set");
	AST_AP_NONE: assert property ((chk.valid && (chk_pa.access_permission_code == // [R03]
		`TLK_AP_NONE)) |=> chk_fault)
		else $error("code 000 did not fault");
	AST_AP_SUPV: assert property ((chk.valid && chk.user && // [R03]
		(chk_pa.access_permission_code == `TLK_AP_SUPV)) |=> chk_fault)
		else $error("user access to code 001 did not fault");
	AST_XN: assert property ((chk.valid && chk.execute && chk_xn) |=> chk_fault) // [R07]
		else $error("execute-never region did not fault");
	AST_AP_FULL: assert property ((chk.valid && !chk.execute && // [R04]
		(chk_pa.access_permission_code == `TLK_AP_FULL)) |=> !chk_fault)
		else $error("code 011 faulted");
	AST_AP_RO: assert property ((chk.valid && chk.write && // [R05]
		(chk_pa.access_permission_code == `TLK_AP_ALL_RO_A)) |=> chk_fault)
		else $error("write to read-only region did not fault");
	AST_EXTENT: assert property ((chk.valid && (chk_pa.region_extent == `TLK_SZ_4K)) // [R02]
		|=> (chk_extent_log2 == `TLK_SHIFT_4K))
		else $error("4KB extent decoded wrongly");

	COV_WALK_DONE: cover property (take_inv ##1 (!irq_pending)[*8] ##1 req_ready);
	COV_ABORT: cover property (abort_valid);
	COV_LOCK_RW: cover property ((take && req.write && (req.op == tlk_pkg::TLK_OP_PA))
		##[1:8] rd_valid);
	COV_GLOBAL_KEPT: cover property ((state_q == tlk_pkg::TLK_WALK) && glob_q[walk_idx_q]
		&& valid_q[walk_idx_q]);

endmodule

// ===== dv/tlk_core_model.sv
`timescale 1ns/1ps
module tlk_core_model
(
	input  wire logic         clock,
	input  wire logic         req_ready,
	output tlk_pkg::tlk_req_t req
);
	initial req = '0;

	// Holds the op through any stall, up to the edge that samples ready high
	task automatic issue(input logic w, input tlk_pkg::tlk_op_t op, input logic [31:0] d);
		@(posedge clock);
		req <= {1'b1, w, op, d, 32'h0000_1000};
		@(posedge clock);
		while (req_ready !== 1'b1)
			@(posedge clock);
		req <= '0;
	endtask

	// Index first, physical word last so the commit sees all staging
	task automatic put(input logic [2:0] i, input logic [31:0] va, pa, at);
		issue(1'b1, tlk_pkg::TLK_OP_SEL_WR, {29'h0, i});
		issue(1'b1, tlk_pkg::TLK_OP_VA, va);
		issue(1'b1, tlk_pkg::TLK_OP_ATTR, at);
		issue(1'b1, tlk_pkg::TLK_OP_PA, pa);
	endtask

	task automatic sel_rd(input logic [2:0] i);
		issue(1'b1, tlk_pkg::TLK_OP_SEL_RD, {29'h0, i});
	endtask
endmodule

// ===== dv/tb.sv
`timescale 1ns/1ps
`include "tlk_regs.svh"
module tb;
	logic                clock;
	logic                reset;
	tlk_pkg::tlk_req_t   req;
	logic                req_ready;
	logic [31:0]         rd_data;
	logic                rd_valid;
	logic                irq_pending;
	logic                abort_valid;
	logic [31:0]         link_return_register;
	tlk_pkg::tlk_fill_t  fill;
	tlk_pkg::tlk_chk_t   chk;
	logic                chk_done;
	logic                chk_fault;
	logic [4:0]          chk_extent_log2;
	int                  n_errors = 0;
	int                  n_tests = 0;
	logic [31:0]         d;
	// Fault mask per code, bit index {user, write}
	logic [3:0]          ftab [8] = '{4'hf, 4'hc, 4'h8, 4'h0, 4'hf, 4'he, 4'ha, 4'ha};
	logic [4:0]          xtab [4] = '{5'h18, 5'h0c, 5'h10, 5'h14};

	tlk_lockdown i_dut (.clock(clock), .reset(reset), .req(req), .req_ready(req_ready),
		.rd_data(rd_data), .rd_valid(rd_valid), .irq_pending(irq_pending),
		.abort_valid(abort_valid), .link_return_register(link_return_register),
		.fill(fill), .chk(chk), .chk_done(chk_done), .chk_fault(chk_fault),
		.chk_extent_log2(chk_extent_log2));
	tlk_core_model i_core (.clock(clock), .req_ready(req_ready), .req(req));

	initial clock = 1'b0;
	always #5 clock = ~clock;

	task automatic check(input string what, input logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Bounded wait of up to four edges, but the answer pulse must already be high just after the take edge
	task automatic get(input tlk_pkg::tlk_op_t op, output logic [31:0] v);
		int k;
		i_core.issue(1'b0, op, 32'h0);
		k = 0;
		#1;
		while (rd_valid !== 1'b1 && k < 4)
		begin
			@(posedge clock);
			#1;
			k++;
		end
		check("rd_valid", rd_valid, 1);
		check("rd latency", k, 0);
		v = rd_data;
	endtask

	task automatic valid_is(input logic [2:0] i, input logic e);
		i_core.sel_rd(i);
		get(tlk_pkg::TLK_OP_PA, d);
		check("entry valid", d[0], e);
	endtask

	task automatic probe(input logic u, w, x, fx, input logic [4:0] ex);
		@(posedge clock);
		chk <= {1'b1, 3'h1, u, w, x};
		@(posedge clock);
		chk <= '0;
		#1;
		check("chk_done", chk_done, 1);
		check("chk_fault", chk_fault, fx);
		check("extent", chk_extent_log2, ex);
	endtask

	task automatic load(input logic [2:0] i, input logic g, input logic [31:0] va);
		@(posedge clock);
		fill <= {1'b1, i, g, va, 32'h0000_2001, 32'h0};
		@(posedge clock);
		fill <= '0;
	endtask

	// Full walk: stalled for exactly eight cycles after the take
	task automatic inv(input logic [31:0] id);
		i_core.issue(1'b1, tlk_pkg::TLK_OP_INV_ADDRESS_SPACE_IDENTIFIER, id);
		#1;
		check("stall", req_ready, 0);
		repeat (7) @(posedge clock);
		#1;
		check("stall end-1", req_ready, 0);
		@(posedge clock);
		#1;
		check("stall end", req_ready, 1);
	endtask

	initial
	begin
		#100us;
		n_errors++;
		$display("watchdog expired");
		wrap_up();
	end

	initial
	begin
		int a;
		int k;
		reset = 1'b1;
		irq_pending = 1'b0;
		fill = '0;
		chk = '0;
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		#1;
		check("ready after reset", req_ready, 1);
		check("abort after reset", abort_valid, 0);
		i_core.put(3'h3, 32'habcd_e05a, 32'h1234_5f7b, 32'hffff_fabc);
		i_core.sel_rd(3'h3);
		get(tlk_pkg::TLK_OP_PA, d);
		check("pa word", d, 32'h1234_5f7b & ~`TLK_PA_RSV_MASK);
		get(tlk_pkg::TLK_OP_ATTR, d);
		check("attr word", d, 32'hffff_fabc & `TLK_ATTR_MASK);
		get(tlk_pkg::TLK_OP_VA, d);
		check("va word", d, 32'habcd_e05a);
		$display("field test done");
		for (a = 0; a < 8; a++)
		begin
			i_core.put(3'h1, 32'h0, {20'h1, 4'h0, a[1:0], 2'h0, a[2:0], 1'b1}, {25'h0, a[0], 6'h0});
			for (k = 0; k < 4; k++)
				probe(k[1], k[0], 1'b0, ftab[a][k[1:0]], xtab[a[1:0]]);
			probe(1'b0, 1'b0, 1'b1, ftab[a][0] | a[0], xtab[a[1:0]]);
		end
		$display("permission test done");
		i_core.put(3'h0, 32'h5, 32'h0000_1001, 32'h0);
		i_core.put(3'h4, 32'h6, 32'h0000_1001, 32'h0);
		load(3'h2, 1'b1, 32'h5);
		inv(32'h5);
		valid_is(3'h0, 1'b0);
		valid_is(3'h4, 1'b1);
		valid_is(3'h2, 1'b1);
		$display("invalidate test done");
		i_core.put(3'h6, 32'h5, 32'h0000_1001, 32'h0);
		i_core.issue(1'b1, tlk_pkg::TLK_OP_INV_ADDRESS_SPACE_IDENTIFIER, 32'h5);
		repeat (2) @(posedge clock);
		irq_pending <= 1'b1;
		k = 0;
		while (abort_valid !== 1'b1 && k < 5)
		begin
			@(posedge clock);
			#1;
			k++;
		end
		check("abort", abort_valid, 1);
		check("link", link_return_register, 32'h0000_1004);
		check("ready on abort", req_ready, 1);
		@(posedge clock);
		irq_pending <= 1'b0;
		valid_is(3'h6, 1'b1);
		load(3'h7, 1'b0, 32'h5);
		inv(32'h5);
		valid_is(3'h6, 1'b0);
		valid_is(3'h7, 1'b0);
		$display("abort test done");
		wrap_up();
	end
endmodule
